// ===== rtl/smbc_cfg.svh
// Constants for the stacked memory bus control block
//--------------------------------------------------------------
//--------------------------------------------------------------
`ifndef SMBC_CFG_SVH
`define SMBC_CFG_SVH

// Bus shape
`define SMBC_ADDR_W 26
`define SMBC_DATA_W 16
`define SMBC_ADDR_ONE 26'h1
`define SMBC_CORE_SYNC_W 56
`define SMBC_LINK_SYNC_W 33

// Die population of the stack
`define SMBC_FLASH_DIES 3
`define SMBC_PSRAM_DIES 2
`define SMBC_SRAM_PRESENT 1

// Wait polarity bit value for an active-high wait
`define SMBC_WAIT_POL_HIGH 1'b1

`endif

// ===== rtl/smbc_pkg.sv
// Types shared by the stacked memory bus control block
package smbc_pkg;

    typedef enum logic [1:0] {
        SMBC_MODE_RESET,
        SMBC_MODE_ASYNC,
        SMBC_MODE_SYNC
    } smbc_mode_t;

endpackage : smbc_pkg

// ===== rtl/smbc_sync.sv
// Two-flop synchroniser for a group of levels
module smbc_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    // First stage feeds only the second one
    always_ff @(posedge clk_i) begin
        meta <= d_i;
        q_o <= meta;
    end

endmodule : smbc_sync

// ===== rtl/smbc_bus_ctrl.sv
// Control-pin logic of the stacked memory package toward the host bus
`include "smbc_cfg.svh"

module smbc_bus_ctrl (
    // Core clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Bus clock from the host
    input wire logic link_clk_i,
    // Flash control pins
    input wire logic [2:0] flash_ce_n_i,
    input wire logic [1:0] flash_oe_n_i,
    input wire logic flash_we_n_i,
    input wire logic flash_reset_n_i,
    input wire logic address_valid_n_i,
    // Shared address and data pins
    input wire logic [`SMBC_ADDR_W-1:0] addr_i,
    input wire logic [`SMBC_DATA_W-1:0] data_i,
    // RAM control pins
    input wire logic sram_select_low_n_i,
    input wire logic sram_select_high_i,
    input wire logic [1:0] psram_sel_n_i,
    input wire logic ram_oe_n_i,
    input wire logic ram_we_n_i,
    // Wait pin
    output logic wait_o,
    output logic wait_oe_o,
    // Flash core side
    input wire logic wait_polarity_bit_i,
    input wire logic set_sync_mode_i,
    input wire logic set_async_mode_i,
    input wire logic flash_write_mode_i,
    input wire logic read_data_valid_i,
    output smbc_pkg::smbc_mode_t flash_mode_o,
    output logic [2:0] flash_sel_o,
    output logic [2:0] flash_dq_oe_o,
    output logic flash_wr_stb_o,
    output logic [`SMBC_ADDR_W-1:0] flash_wr_addr_o,
    output logic [`SMBC_DATA_W-1:0] flash_wr_data_o,
    output logic [`SMBC_ADDR_W-1:0] async_addr_o,
    // RAM core side
    output logic sram_active_o,
    output logic [1:0] psram_active_o,
    output logic ram_dq_oe_o,
    output logic ram_write_o,
    // Burst address, bus clock domain
    output logic [`SMBC_ADDR_W-1:0] burst_addr_o,
    output logic burst_addr_valid_o
);

    //----------------------------------------------------------
    // Pin synchronisation into the core clock
    //----------------------------------------------------------
    logic [`SMBC_CORE_SYNC_W-1:0] core_sync;
    logic [2:0] s_ce_n;
    logic [1:0] s_foe_n;
    logic s_fwe_n, s_frst_n, s_adv_n, s_cs_low_n, s_cs_high, s_roe_n, s_rwe_n;
    logic [1:0] s_ps_n;
    logic [`SMBC_ADDR_W-1:0] s_addr;
    logic [`SMBC_DATA_W-1:0] s_data;

    smbc_sync #(.W(`SMBC_CORE_SYNC_W)) u_core_sync (
        .clk_i(clock_i),
        .d_i({flash_ce_n_i, flash_oe_n_i, flash_we_n_i, flash_reset_n_i,
              address_valid_n_i, sram_select_low_n_i, sram_select_high_i,
              psram_sel_n_i, ram_oe_n_i, ram_we_n_i, addr_i, data_i}),
        .q_o(core_sync)
    );

    assign {s_ce_n, s_foe_n, s_fwe_n, s_frst_n, s_adv_n, s_cs_low_n,
            s_cs_high, s_ps_n, s_roe_n, s_rwe_n, s_addr, s_data} = core_sync;

    //----------------------------------------------------------
    // Flash reset and read mode
    //----------------------------------------------------------
    wire flash_rst = !reset_n_i || !s_frst_n;
    smbc_pkg::smbc_mode_t next_mode;

    always_comb begin
        next_mode = flash_mode_o;
        case (flash_mode_o)
            smbc_pkg::SMBC_MODE_RESET: next_mode = smbc_pkg::SMBC_MODE_ASYNC;
            smbc_pkg::SMBC_MODE_ASYNC: begin
                if (set_sync_mode_i) begin
                    next_mode = smbc_pkg::SMBC_MODE_SYNC;
                end
            end
            smbc_pkg::SMBC_MODE_SYNC: begin
                if (set_async_mode_i) begin
                    next_mode = smbc_pkg::SMBC_MODE_ASYNC;
                end
            end
            default: next_mode = smbc_pkg::SMBC_MODE_RESET;
        endcase
        if (flash_rst) begin
            next_mode = smbc_pkg::SMBC_MODE_RESET;
        end
    end

    always_ff @(posedge clock_i) begin
        flash_mode_o <= next_mode;
    end

    wire mode_async = flash_mode_o == smbc_pkg::SMBC_MODE_ASYNC;
    wire mode_sync = flash_mode_o == smbc_pkg::SMBC_MODE_SYNC;

    //----------------------------------------------------------
    // Flash die select and output enables
    //----------------------------------------------------------
    logic [2:0] next_flash_sel, next_flash_oe;

    for (genvar k = 0; k < 3; k++) begin : g_flash
        // Die one has its own enable; dies two and three share the second
        wire oe_n = (k == 0) ? s_foe_n[0] : s_foe_n[1];
        wire present = k < `SMBC_FLASH_DIES;
        assign next_flash_sel[k] = present && !s_ce_n[k] && !flash_rst;
        assign next_flash_oe[k] = next_flash_sel[k] && !oe_n;
    end

    always_ff @(posedge clock_i) begin
        flash_sel_o <= next_flash_sel;
        flash_dq_oe_o <= next_flash_oe;
    end

    //----------------------------------------------------------
    // RAM selects, output enable and write strobe
    //----------------------------------------------------------
    wire sram_present = `SMBC_SRAM_PRESENT != 0;
    wire ram_present = sram_present || (`SMBC_PSRAM_DIES != 0);
    wire next_sram = sram_present && (!s_cs_low_n || s_cs_high);
    logic [1:0] next_psram;

    for (genvar j = 0; j < 2; j++) begin : g_psram
        assign next_psram[j] = (j < `SMBC_PSRAM_DIES) && !s_ps_n[j];
    end

    wire ram_sel = next_sram || |next_psram;
    wire next_ram_oe = ram_present && ram_sel && !s_roe_n;
    wire next_ram_wr = ram_present && ram_sel && !s_rwe_n;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            sram_active_o <= 1'b0;
            psram_active_o <= 2'h0;
            ram_dq_oe_o <= 1'b0;
            ram_write_o <= 1'b0;
        end else begin
            sram_active_o <= next_sram;
            psram_active_o <= next_psram;
            ram_dq_oe_o <= next_ram_oe;
            ram_write_o <= next_ram_wr;
        end
    end

    //----------------------------------------------------------
    // Flash write latch and address latch
    //----------------------------------------------------------
    logic we_d_n, adv_d_n;
    logic [`SMBC_ADDR_W-1:0] addr_prev;
    logic [`SMBC_DATA_W-1:0] data_prev;

    // Values from the cycle before the rise, so a bus that moves with the
    // strobe edge is not picked up
    wire we_rise = !we_d_n && s_fwe_n && |next_flash_sel;
    wire adv_rise = !adv_d_n && s_adv_n;
    wire addr_flow = mode_async && !s_adv_n;

    always_ff @(posedge clock_i) begin
        we_d_n <= s_fwe_n;
        adv_d_n <= s_adv_n;
        addr_prev <= s_addr;
        data_prev <= s_data;
    end

    always_ff @(posedge clock_i) begin
        if (flash_rst) begin
            flash_wr_stb_o <= 1'b0;
            flash_wr_addr_o <= '0;
            flash_wr_data_o <= '0;
        end else begin
            flash_wr_stb_o <= we_rise;
            if (we_rise) begin
                flash_wr_addr_o <= addr_prev;
                flash_wr_data_o <= data_prev;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (flash_rst) begin
            async_addr_o <= '0;
        end else if (addr_flow) begin
            async_addr_o <= s_addr;
        end else if (adv_rise) begin
            async_addr_o <= addr_prev;
        end
    end

    //----------------------------------------------------------
    // Wait pin
    //----------------------------------------------------------
    // Async page reads and writes hold wait; sync reads follow validity
    wire wait_asserted = !mode_sync || flash_write_mode_i || !read_data_valid_i;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            wait_o <= 1'b0;
            wait_oe_o <= 1'b0;
        end else begin
            wait_o <= wait_asserted ^ !wait_polarity_bit_i;
            wait_oe_o <= |next_flash_sel;
        end
    end

    //----------------------------------------------------------
    // Levels handed to the bus clock domain
    //----------------------------------------------------------
    logic x_run, x_sync, x_wait;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            x_run <= 1'b0;
            x_sync <= 1'b0;
            x_wait <= 1'b1;
        end else begin
            x_run <= !flash_rst;
            x_sync <= mode_sync;
            x_wait <= wait_asserted;
        end
    end

    //----------------------------------------------------------
    // Burst address logic on the bus clock
    //----------------------------------------------------------
    logic [`SMBC_LINK_SYNC_W-1:0] link_sync;
    logic l_run, l_sync, l_wait, l_adv_n, l_adv_d_n;
    logic [2:0] l_ce_n;
    logic [`SMBC_ADDR_W-1:0] l_addr;

    smbc_sync #(.W(`SMBC_LINK_SYNC_W)) u_link_sync (
        .clk_i(link_clk_i),
        .d_i({x_run, x_sync, x_wait, address_valid_n_i, flash_ce_n_i, addr_i}),
        .q_o(link_sync)
    );

    assign {l_run, l_sync, l_wait, l_adv_n, l_ce_n, l_addr} = link_sync;

    // The clock may stop between bursts: all state here holds until the next bus clock edge
    wire l_ce = !(&l_ce_n);
    wire l_capture = l_run && l_sync && l_ce && !l_adv_n && l_adv_d_n;
    wire l_step = burst_addr_valid_o && l_ce && l_adv_n && !l_wait;

    always_ff @(posedge link_clk_i) begin
        if (!l_run) begin
            l_adv_d_n <= 1'b1;
            burst_addr_o <= '0;
            burst_addr_valid_o <= 1'b0;
        end else begin
            l_adv_d_n <= l_adv_n;
            if (l_capture) begin
                burst_addr_o <= l_addr;
                burst_addr_valid_o <= 1'b1;
            end else if (!l_ce || !l_sync) begin
                burst_addr_valid_o <= 1'b0;
            end else if (l_step) begin
                burst_addr_o <= burst_addr_o + `SMBC_ADDR_ONE;
            end
        end
    end

    //----------------------------------------------------------
    // Checks
    //----------------------------------------------------------
    sequence s_we_rise;
        !s_fwe_n ##1 (s_fwe_n && |next_flash_sel && !flash_rst);
    endsequence
    sequence s_reset_exit;
        flash_rst ##1 !flash_rst;
    endsequence

    a_flash_oe_float: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (s_foe_n[0] || s_ce_n[0]) |=> !flash_dq_oe_o[0])
        else $error("flash die one drives with enable high");

    a_shared_oe_two: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!s_foe_n[1] && !s_ce_n[2] && !flash_rst) |=> flash_dq_oe_o[2])
        else $error("flash die three not driven by second enable");

    a_wait_float: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (&s_ce_n) |=> !wait_oe_o)
        else $error("wait driven while flash deselected");

    a_wait_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (flash_write_mode_i && !wait_polarity_bit_i) |=> !wait_o)
        else $error("low-true wait not asserted in write mode");

    a_wait_valid: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (mode_sync && read_data_valid_i && !flash_write_mode_i
         && wait_polarity_bit_i == `SMBC_WAIT_POL_HIGH) |=> !wait_o)
        else $error("wait asserted with valid sync data");

    a_wait_polarity: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (mode_async && wait_polarity_bit_i) |=> wait_o)
        else $error("high-true wait not high in async mode");

    a_sram_select: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (s_cs_low_n && !s_cs_high) |=> !sram_active_o)
        else $error("sram active with both selects off");

    a_psram_select: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        psram_active_o[1] |-> $past(!s_ps_n[1]))
        else $error("psram die two active without its select");

    a_ram_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ram_write_o |-> $past(!s_rwe_n && ram_sel))
        else $error("ram write without strobe and select");

    a_write_latch: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        s_we_rise |=> flash_wr_stb_o && flash_wr_data_o == $past(s_data, 2))
        else $error("flash write data not latched at strobe rise");

    a_reset_exit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        s_reset_exit |=> mode_async)
        else $error("flash not in async read after reset");

    a_addr_flow: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        addr_flow && !flash_rst |=> async_addr_o == $past(s_addr))
        else $error("async address not transparent");

    a_burst_capture: assert property (@(posedge link_clk_i) disable iff (!l_run)
        l_capture |=> burst_addr_valid_o && burst_addr_o == $past(l_addr))
        else $error("burst address not captured");

    a_burst_step: assert property (@(posedge link_clk_i) disable iff (!l_run)
        (l_step && l_sync && !l_capture) |=> burst_addr_o == $past(burst_addr_o) + `SMBC_ADDR_ONE)
        else $error("burst address did not advance");

endmodule : smbc_bus_ctrl

// ===== tb/smbc_host_model.sv
// Host side of the shared bus: bus clock within frames and burst beat counting
module smbc_host_model (
    // Frame control from the bench
    input wire logic run_i,
    // Wait pin as seen by the host
    input wire logic wait_i,
    input wire logic pol_i,
    // Bus clock and accepted beats
    output logic link_clk_o,
    output int beats_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands still low between frames; odd offset keeps it unrelated to the core clock
    initial begin
        link_clk_o = 1'b0;
        beats_o = 0;
        #7;
        forever begin
            #16;
            if (run_i) begin
                link_clk_o = ~link_clk_o;
            end else begin
                link_clk_o = 1'b0;
            end
        end
    end

    // Data is taken only on edges where wait sits at its deasserted level
    always @(posedge link_clk_o) begin
        if (wait_i === ~pol_i) begin
            beats_o++;
        end
    end

endmodule : smbc_host_model

// ===== tb/stacked_memory_bus_control_bench.sv
// Self-checking bench for the stacked memory bus control block
`include "smbc_cfg.svh"

module stacked_memory_bus_control_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i = 0, reset_n_i = 0, link_clk, frst = 1, adv = 1, we = 1, slo = 1, shi = 0;
    logic roe = 1, rwe = 1, pol = 1, ssync = 0, sasync = 0, wmode = 0, rdv = 0, run = 1;
    logic [2:0] ce = 3'h7;
    logic [1:0] oe = 2'h3, ps = 2'h3;
    logic [`SMBC_ADDR_W-1:0] addr = '0;
    logic [`SMBC_DATA_W-1:0] data = '0;
    logic wait_o, wait_oe, stb, ram_oe_o, ram_wr, sram_act, bvalid;
    logic [2:0] sel, dq_oe;
    logic [1:0] ps_act;
    logic [`SMBC_ADDR_W-1:0] wr_addr, aaddr, baddr, b1;
    logic [`SMBC_DATA_W-1:0] wr_data;
    smbc_pkg::smbc_mode_t mode;
    int n_mismatch = 0, cmp_count = 0, beats, b0;
    logic [31:0] r = 32'h2ab9d980;

    always #5 clock_i = ~clock_i;

    smbc_host_model host_u (.run_i(run), .wait_i(wait_o), .pol_i(pol), .link_clk_o(link_clk),
        .beats_o(beats));

    smbc_bus_ctrl dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk),
        .flash_ce_n_i(ce), .flash_oe_n_i(oe), .flash_we_n_i(we), .flash_reset_n_i(frst),
        .address_valid_n_i(adv), .addr_i(addr), .data_i(data), .sram_select_low_n_i(slo),
        .sram_select_high_i(shi), .psram_sel_n_i(ps), .ram_oe_n_i(roe), .ram_we_n_i(rwe),
        .wait_o(wait_o), .wait_oe_o(wait_oe), .wait_polarity_bit_i(pol),
        .set_sync_mode_i(ssync), .set_async_mode_i(sasync), .flash_write_mode_i(wmode),
        .read_data_valid_i(rdv), .flash_mode_o(mode), .flash_sel_o(sel),
        .flash_dq_oe_o(dq_oe), .flash_wr_stb_o(stb), .flash_wr_addr_o(wr_addr),
        .flash_wr_data_o(wr_data), .async_addr_o(aaddr), .sram_active_o(sram_act),
        .psram_active_o(ps_act), .ram_dq_oe_o(ram_oe_o), .ram_write_o(ram_wr),
        .burst_addr_o(baddr), .burst_addr_valid_o(bvalid));

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [2:0] exp_dq(input logic [2:0] c, input logic [1:0] o);
        return ~c & {~o[1], ~o[1], ~o[0]};
    endfunction : exp_dq

    function automatic logic ram_any(input logic l, input logic h, input logic [1:0] p);
        return ~l | h | ~p[0] | ~p[1];
    endfunction : ram_any

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
    endtask : step

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic timed_out();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask : timed_out

    //--------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------
    initial begin
        int k;
        step(10);
        // Bus clock ran through reset so the burst logic took its reset; now idle
        reset_n_i <= 1'b1;
        run <= 1'b0;
        step(6);
        chk({30'h0, mode}, {30'h0, smbc_pkg::SMBC_MODE_ASYNC});
        // Random pin patterns; hold each long enough to pass the synchronisers
        for (int i = 0; i < 40; i++) begin
            r = lfsr(r);
            ce <= r[2:0]; oe <= r[4:3]; slo <= r[5]; shi <= r[6]; ps <= r[8:7];
            roe <= r[9]; rwe <= r[10]; pol <= r[11];
            step(6);
            chk({29'h0, sel}, {29'h0, ~ce});
            chk({29'h0, dq_oe}, {29'h0, exp_dq(ce, oe)});
            chk({31'h0, sram_act}, {31'h0, ~slo | shi});
            chk({30'h0, ps_act}, {30'h0, ~ps});
            chk({31'h0, ram_oe_o}, {31'h0, ~roe & ram_any(slo, shi, ps)});
            chk({31'h0, ram_wr}, {31'h0, ~rwe & ram_any(slo, shi, ps)});
            chk({31'h0, wait_oe}, {31'h0, ~&ce});
            if (~&ce) chk({31'h0, wait_o}, {31'h0, pol});
        end
        // Flash write latched on the strobe's rise
        r = lfsr(r);
        ce <= 3'b110; we <= 1'b0; addr <= r[25:0]; data <= r[31:16];
        step(3);
        we <= 1'b1;
        k = 0;
        while (stb !== 1'b1) begin
            step(1);
            if (++k > 12) timed_out();
        end
        chk({6'h0, wr_addr}, {6'h0, r[25:0]});
        chk({16'h0, wr_data}, {16'h0, r[31:16]});
        // Asynchronous read address: flow-through while low, held after the rise
        adv <= 1'b0; addr <= 26'h155aa55;
        step(5);
        chk({6'h0, aaddr}, 32'h155aa55);
        addr <= 26'h2aa55aa;
        step(5);
        chk({6'h0, aaddr}, 32'h2aa55aa);
        adv <= 1'b1;
        step(3);
        addr <= 26'h0123456;
        step(5);
        chk({6'h0, aaddr}, 32'h2aa55aa);
        // Synchronous mode and its wait levels
        ssync <= 1'b1; pol <= 1'b1; rdv <= 1'b0;
        step(1);
        ssync <= 1'b0;
        step(5);
        chk({30'h0, mode}, {30'h0, smbc_pkg::SMBC_MODE_SYNC});
        chk({31'h0, wait_o}, 32'h1);
        rdv <= 1'b1;
        step(5);
        chk({31'h0, wait_o}, 32'h0);
        wmode <= 1'b1;
        step(5);
        chk({31'h0, wait_o}, 32'h1);
        pol <= 1'b0;
        step(3);
        chk({31'h0, wait_o}, 32'h0);
        wmode <= 1'b0; rdv <= 1'b0; pol <= 1'b1; run <= 1'b1;
        // Burst: capture on the clock edge with the strobe low, then count up
        repeat (6) @(posedge link_clk);
        step(1);
        b0 = beats;
        adv <= 1'b0; addr <= 26'h3fffff0;
        k = 0;
        while (bvalid !== 1'b1) begin
            @(posedge link_clk);
            if (++k > 20) timed_out();
        end
        @(negedge link_clk);
        chk({6'h0, baddr}, 32'h3fffff0);
        chk(beats, b0);
        step(1);
        adv <= 1'b1; rdv <= 1'b1;
        repeat (8) @(posedge link_clk);
        @(negedge link_clk);
        b1 = baddr;
        @(negedge link_clk);
        chk({6'h0, baddr}, {6'h0, b1 + `SMBC_ADDR_ONE});
        chk({31'h0, beats != b0}, 32'h1);
        chk({6'h0, aaddr}, 32'h3fffff0);
        step(1);
        run <= 1'b0;
        sasync <= 1'b1;
        step(1);
        sasync <= 1'b0;
        step(2);
        chk({30'h0, mode}, {30'h0, smbc_pkg::SMBC_MODE_ASYNC});
        // Flash reset blocks selection, exit returns to asynchronous reads
        frst <= 1'b0;
        step(6);
        chk({30'h0, mode}, {30'h0, smbc_pkg::SMBC_MODE_RESET});
        chk({29'h0, sel}, 32'h0);
        frst <= 1'b1;
        step(6);
        chk({30'h0, mode}, {30'h0, smbc_pkg::SMBC_MODE_ASYNC});
        wrap_up();
    end

endmodule : stacked_memory_bus_control_bench
